// file: hw/lps_event_select.sv
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

module lps_event_select (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wishbone slave
    input wire lps_pkg::lpsWbReq_t wbReq,
    output logic [31:0] wbDatO,
    output logic wbAck,
    // link-layer event sources, same clock
    input wire lps_pkg::lpsDatapath_t llEvents,
    input wire lps_pkg::lpsPwrMsg_t pwrMsg,
    // tracked power state
    output lps_pkg::lpsPwr_t txPwrState,
    output lps_pkg::lpsPwr_t rxPwrState
);
    import lps_pkg::*;

    // ==========================================================
    // write and condition helpers
    // byte lanes let software touch the event code or the unit mask alone; edge and enable share one lane
    function automatic logic [31:0] applySel(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : applySel

    function automatic logic selHit(input logic [7:0] umask,
                                   input logic [7:0] cond);
        return |(umask & cond);
    endfunction : selHit

    // shutdown is tested in several places below
    function automatic logic isShut(input lpsPwr_t s);
        return s == LPS_PWR_SHUT;
    endfunction : isShut

    // ==========================================================
    // power state tracking per direction
    lpsPwr_t txPwr_q;
    lpsPwr_t txPwr_d;
    lpsPwr_t rxPwr_q;
    lpsPwr_t rxPwr_d;
    logic ourPend_q;
    logic ourPend_d;
    lpsPwr_t ourTgt_q;
    lpsPwr_t ourTgt_d;
    logic peerPend_q;
    logic peerPend_d;
    lpsPwr_t peerTgt_q;
    lpsPwr_t peerTgt_d;

    // our request is answered by the peer's rx side
    wire logic ourAccepted = pwrMsg.rxAck & ourPend_q;
    wire logic ourRefused = pwrMsg.rxNack & ourPend_q;
    // the peer's request is answered by us
    wire logic peerAccepted = pwrMsg.txAck & peerPend_q;
    wire logic peerRefused = pwrMsg.txNack & peerPend_q;

    always_comb begin
        txPwr_d = txPwr_q;
        rxPwr_d = rxPwr_q;
        ourPend_d = ourPend_q;
        ourTgt_d = ourTgt_q;
        peerPend_d = peerPend_q;
        peerTgt_d = peerTgt_q;

        if (ourAccepted) begin
            txPwr_d = ourTgt_q;
            ourPend_d = 1'b0;
        end else if (ourRefused) begin
            ourPend_d = 1'b0;
        end

        if (peerAccepted) begin
            rxPwr_d = peerTgt_q;
            peerPend_d = 1'b0;
        end else if (peerRefused) begin
            peerPend_d = 1'b0;
        end

        // a new request replaces one still waiting
        if (pwrMsg.ourReq) begin
            ourPend_d = 1'b1;
            ourTgt_d = pwrMsg.ourReqTgt;
        end
        if (pwrMsg.peerReq) begin
            peerPend_d = 1'b1;
            peerTgt_d = pwrMsg.peerReqTgt;
        end

        // training overrides everything; ready brings up full power
        if (!pwrMsg.phyReady) begin
            txPwr_d = LPS_PWR_INIT;
            rxPwr_d = LPS_PWR_INIT;
            ourPend_d = 1'b0;
            peerPend_d = 1'b0;
        end else begin
            if (txPwr_q == LPS_PWR_INIT) begin
                txPwr_d = LPS_PWR_FULL;
            end
            if (rxPwr_q == LPS_PWR_INIT) begin
                rxPwr_d = LPS_PWR_FULL;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txPwr_q <= LPS_PWR_INIT;
            rxPwr_q <= LPS_PWR_INIT;
            ourPend_q <= 1'b0;
            ourTgt_q <= LPS_PWR_INIT;
            peerPend_q <= 1'b0;
            peerTgt_q <= LPS_PWR_INIT;
        end else begin
            txPwr_q <= txPwr_d;
            rxPwr_q <= rxPwr_d;
            ourPend_q <= ourPend_d;
            ourTgt_q <= ourTgt_d;
            peerPend_q <= peerPend_d;
            peerTgt_q <= peerTgt_d;
        end
    end

    // ==========================================================
    // raw conditions
    wire logic [5:0] thr;
    wire logic [5:0] reqCrd = llEvents.reqCredits;
    wire logic [5:0] dataCrd = llEvents.dataCredits;
    wire logic [5:0] ackCrd = llEvents.ackCredits;

    wire logic drsOk = llEvents.drsValid & llEvents.drsCandidate;
    wire logic [7:0] directCond = {
        6'h00,
        drsOk & llEvents.drsToLink,
        drsOk & llEvents.drsToCore
    };

    // credits are unsigned; the between causes use thr
    wire logic reqLe2 = reqCrd <= 6'h02;
    wire logic ackLe3 = ackCrd <= 6'h03;
    wire logic dataEq0 = dataCrd == 6'h00;
    wire logic reqBtw = (reqCrd > 6'h02) && (reqCrd <= thr);
    wire logic dataBtw = (dataCrd > 6'h00) && (dataCrd <= thr);

    wire logic [7:0] shortCond = {
        ackCrd == 6'h03,
        ackCrd == 6'h02,
        ackCrd == 6'h01,
        ackCrd == 6'h00,
        dataEq0,
        reqCrd == 6'h02,
        reqCrd == 6'h01,
        reqCrd == 6'h00
    };

    wire logic [7:0] bypCond = {
        3'h0,
        llEvents.gvBlock,
        llEvents.bgfStall,
        ackLe3,
        dataEq0,
        reqLe2
    };

    wire logic [7:0] rxqCond = {
        1'b0,
        llEvents.gvBlock,
        llEvents.bgfStall,
        ackLe3,
        dataBtw,
        dataEq0,
        reqBtw,
        reqLe2
    };

    wire logic [7:0] slot2Cond = {
        4'h0,
        llEvents.slot2Ack,
        llEvents.slot2Vn1,
        llEvents.slot2Vn0,
        llEvents.slot2Vna
    };

    // only responses to shutdown requests count
    wire logic ourShutAcc = ourAccepted & isShut(ourTgt_q);
    wire logic peerShutAcc = peerAccepted & isShut(peerTgt_q);
    wire logic ourShutRef = ourRefused & isShut(ourTgt_q);
    wire logic peerShutRef = peerRefused & isShut(peerTgt_q);
    wire logic [7:0] acceptCond = {6'h00, peerShutAcc, ourShutAcc};
    wire logic [7:0] refuseCond = {6'h00, peerShutRef, ourShutRef};

    wire logic shutNow = isShut(txPwr_q) | isShut(rxPwr_q);
    wire logic rxReducedNow = rxPwr_q == LPS_PWR_REDUCED;
    wire logic phyInitNow = rxPwr_q == LPS_PWR_INIT;

    // ==========================================================
    // event selection per counter
    logic [31:0] ctl_q [LPS_NUM_CTR];
    logic [31:0] cnt_q [LPS_NUM_CTR];
    logic prevCond_q [LPS_NUM_CTR];
    logic [LPS_NUM_CTR-1:0] condNow;
    logic [LPS_NUM_CTR-1:0] incNow;
    logic [LPS_NUM_CTR-1:0] shutInc;

    for (genvar i = 0; i < LPS_NUM_CTR; i++) begin : g_sel
        wire logic [7:0] evCode = ctl_q[i][LPS_EV_LSB +: 8];
        wire logic [7:0] umask = ctl_q[i][LPS_UM_LSB +: 8];
        wire logic edgeOn = ctl_q[i][LPS_EDGE_BIT];
        wire logic enOn = ctl_q[i][LPS_EN_BIT];
        assign condNow[i] =
            (evCode == LPS_EV_TICK) ? 1'b1 :
            (evCode == LPS_EV_DIRECT) ? selHit(umask, directCond) :
            (evCode == LPS_EV_CRD_SHORT) ? selHit(umask, shortCond) :
            (evCode == LPS_EV_BYP_BLK) ? selHit(umask, bypCond) :
            (evCode == LPS_EV_RXQ_BLK) ? selHit(umask, rxqCond) :
            (evCode == LPS_EV_CRD_RET) ? llEvents.crdRetBlocked :
            (evCode == LPS_EV_SLOT2) ? selHit(umask, slot2Cond) :
            (evCode == LPS_EV_ACCEPT) ? selHit(umask, acceptCond) :
            (evCode == LPS_EV_REFUSE) ? selHit(umask, refuseCond) :
            (evCode == LPS_EV_SHUT_RES) ? shutNow :
            (evCode == LPS_EV_RX_REDUCED) ? rxReducedNow :
            (evCode == LPS_EV_PHY_INIT) ? phyInitNow :
            1'b0;

        // edge mode turns residency into entry counts
        wire logic risen = condNow[i] & ~prevCond_q[i];
        assign incNow[i] = enOn & (edgeOn ? risen : condNow[i]);
        assign shutInc[i] = incNow[i] & (evCode == LPS_EV_SHUT_RES);
    end

    // ==========================================================
    // wishbone slave
    logic wbAck_q;
    wire logic busReq = wbReq.cyc & wbReq.stb & ~wbAck_q;
    wire logic [7:0] wordAdr = {wbReq.adr[7:2], 2'b00};

    // unmapped words read zero and drop writes
    wire logic hitThr = wordAdr == LPS_THR_OFF;
    wire logic hitStat = wordAdr == LPS_STAT_OFF;
    wire logic [1:0] ctrIdx = wbReq.adr[3:2];
    wire logic hitCtl = (wordAdr >= LPS_CTL0_OFF) &&
                        (wordAdr < LPS_CNT0_OFF);
    wire logic hitCnt = (wordAdr >= LPS_CNT0_OFF) &&
                        (wordAdr < LPS_CNT0_OFF + LPS_CTR_STRIDE * 8'h04);

    logic [31:0] wbDat_q;
    logic [31:0] wbDat_d;
    // threshold only feeds the between causes
    logic [5:0] thr_q;
    logic shutSeen_q;

    assign thr = thr_q;

    always_comb begin
        wbDat_d = 32'h0000_0000;
        if (hitCtl) begin
            wbDat_d = ctl_q[ctrIdx];
        end else if (hitCnt) begin
            wbDat_d = cnt_q[ctrIdx];
        end else if (hitThr) begin
            wbDat_d = {26'h0, thr_q};
        end else if (hitStat) begin
            wbDat_d[LPS_ST_TX_LSB +: 3] = txPwr_q;
            wbDat_d[LPS_ST_RX_LSB +: 3] = rxPwr_q;
            wbDat_d[LPS_ST_SEEN_BIT] = shutSeen_q;
            wbDat_d[LPS_ST_RATIO_LSB +: 4] = LPS_XFER_PER_CLK;
        end
    end

    // one wait state: ack one edge after the request is seen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wbAck_q <= 1'b0;
            wbDat_q <= 32'h0000_0000;
        end else begin
            wbAck_q <= busReq;
            wbDat_q <= busReq ? wbDat_d : 32'h0000_0000;
        end
    end

    // write takes effect at the acking edge, request still held
    wire logic wrNow = wbReq.cyc & wbReq.stb & wbReq.we & wbAck_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            thr_q <= LPS_THR_RST;
        end else if (wrNow && hitThr && wbReq.sel[0]) begin
            thr_q <= wbReq.dat[5:0];
        end
    end

    // sticky: reduced-width edge counts are suspect once set
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shutSeen_q <= 1'b0;
        end else if (|shutInc) begin
            shutSeen_q <= 1'b1;
        end else if (wrNow && hitStat && wbReq.sel[1] &&
                     wbReq.dat[LPS_ST_SEEN_BIT]) begin
            shutSeen_q <= 1'b0;
        end
    end

    // ==========================================================
    // counters; a software write beats an increment
    for (genvar i = 0; i < LPS_NUM_CTR; i++) begin : g_ctr
        wire logic wrCtl = wrNow & hitCtl & (ctrIdx == 2'(i));
        wire logic wrCnt = wrNow & hitCnt & (ctrIdx == 2'(i));

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                ctl_q[i] <= LPS_CTL_RST;
                cnt_q[i] <= LPS_CNT_RST;
                prevCond_q[i] <= 1'b0;
            end else begin
                prevCond_q[i] <= condNow[i];

                if (wrCtl) begin
                    ctl_q[i] <= applySel(ctl_q[i], wbReq.dat,
                                         wbReq.sel) & LPS_CTL_WMASK;
                end

                if (wrCnt) begin
                    cnt_q[i] <= applySel(cnt_q[i], wbReq.dat, wbReq.sel);
                end else if (incNow[i]) begin
                    cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
                end
            end
        end
    end

    // ==========================================================
    // outputs
    // every output comes straight from a flop
    assign wbAck = wbAck_q;
    assign wbDatO = wbDat_q;
    assign txPwrState = txPwr_q;
    assign rxPwrState = rxPwr_q;

endmodule : lps_event_select

// file: inc/lps_pkg.sv
package lps_pkg;

    // ==========================================================
    // bus geometry
    localparam int LPS_DW = 32;
    localparam int LPS_AW = 8;
    localparam int LPS_NUM_CTR = 4;
    localparam int LPS_CRD_W = 6;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] LPS_CTL0_OFF = 8'h00;
    localparam logic [7:0] LPS_CNT0_OFF = 8'h10;
    localparam logic [7:0] LPS_THR_OFF = 8'h20;
    localparam logic [7:0] LPS_STAT_OFF = 8'h24;
    localparam logic [7:0] LPS_CTR_STRIDE = 8'h04;

    // ==========================================================
    // field positions
    localparam int LPS_EV_LSB = 0;
    localparam int LPS_UM_LSB = 8;
    localparam int LPS_EDGE_BIT = 18;
    localparam int LPS_EN_BIT = 22;
    localparam int LPS_ST_TX_LSB = 0;
    localparam int LPS_ST_RX_LSB = 4;
    localparam int LPS_ST_SEEN_BIT = 8;
    localparam int LPS_ST_RATIO_LSB = 12;
    localparam logic [31:0] LPS_CTL_WMASK = 32'h0044ffff;

    // ==========================================================
    // reset values
    localparam logic [31:0] LPS_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] LPS_CNT_RST = 32'h0000_0000;
    localparam logic [5:0] LPS_THR_RST = 6'h08;

    // ==========================================================
    // timing: link-layer clock is the transfer rate divided by this
    localparam logic [3:0] LPS_XFER_PER_CLK = 4'h8;

    // ==========================================================
    // event codes
    localparam logic [7:0] LPS_EV_TICK = 8'h01;
    localparam logic [7:0] LPS_EV_DIRECT = 8'h12;
    localparam logic [7:0] LPS_EV_BYP_BLK = 8'h14;
    localparam logic [7:0] LPS_EV_RXQ_BLK = 8'h15;
    localparam logic [7:0] LPS_EV_CRD_RET = 8'h16;
    localparam logic [7:0] LPS_EV_CRD_SHORT = 8'h18;
    localparam logic [7:0] LPS_EV_PHY_INIT = 8'h20;
    localparam logic [7:0] LPS_EV_SHUT_RES = 8'h21;
    localparam logic [7:0] LPS_EV_ACCEPT = 8'h22;
    localparam logic [7:0] LPS_EV_REFUSE = 8'h23;
    localparam logic [7:0] LPS_EV_RX_REDUCED = 8'h25;
    localparam logic [7:0] LPS_EV_SLOT2 = 8'h46;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        LPS_PWR_INIT, LPS_PWR_FULL, LPS_PWR_CGATED, LPS_PWR_REDUCED,
        LPS_PWR_SHUT
    } lpsPwr_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } lpsWbReq_t;

    typedef struct packed {
        logic drsValid;
        logic drsCandidate;
        logic drsToCore;
        logic drsToLink;
        logic [5:0] reqCredits;
        logic [5:0] dataCredits;
        logic [5:0] ackCredits;
        logic bgfStall;
        logic gvBlock;
        logic crdRetBlocked;
        logic slot2Vna;
        logic slot2Vn0;
        logic slot2Vn1;
        logic slot2Ack;
    } lpsDatapath_t;

    typedef struct packed {
        logic phyReady;
        logic ourReq;
        lpsPwr_t ourReqTgt;
        logic rxAck;
        logic rxNack;
        logic peerReq;
        lpsPwr_t peerReqTgt;
        logic txAck;
        logic txNack;
    } lpsPwrMsg_t;

endpackage : lps_pkg

// file: tb/lps_chk.sv
`timescale 1ns/1ps
module lps_chk
    import lps_pkg::*;
(
    // clock, reset and bus
    input wire logic mclk,
    input wire logic rst_n,
    input wire lps_pkg::lpsWbReq_t wbReq,
    input wire logic [31:0] wbDatO,
    input wire logic wbAck,
    // link side
    input wire lps_pkg::lpsDatapath_t llEvents,
    input wire lps_pkg::lpsPwrMsg_t pwrMsg,
    input wire lps_pkg::lpsPwr_t txPwrState,
    input wire lps_pkg::lpsPwr_t rxPwrState
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // ====================
    // handshakes: request, then an accept a cycle later
    sequence s_own;
        pwrMsg.phyReady && pwrMsg.ourReq ##1 pwrMsg.phyReady
            && !pwrMsg.ourReq && pwrMsg.rxAck && !pwrMsg.rxNack;
    endsequence
    sequence s_peer;
        pwrMsg.phyReady && pwrMsg.peerReq ##1 pwrMsg.phyReady
            && !pwrMsg.peerReq && pwrMsg.txAck && !pwrMsg.txNack;
    endsequence
    property p_ack;
        wbReq.cyc && wbReq.stb && !wbAck |=> wbAck;
    endproperty
    property p_ack_drop;
        wbAck |=> !wbAck;
    endproperty
    property p_dat_idle;
        !wbAck |-> wbDatO == 32'h0;
    endproperty
    property p_own_accept;
        s_own |=> txPwrState == $past(pwrMsg.ourReqTgt, 2);
    endproperty
    property p_peer_accept;
        s_peer |=> rxPwrState == $past(pwrMsg.peerReqTgt, 2);
    endproperty
    // refusals fall under these: only an accept moves a direction
    property p_tx_hold;
        pwrMsg.phyReady && !pwrMsg.rxAck && txPwrState != LPS_PWR_INIT
            |=> $stable(txPwrState);
    endproperty
    property p_rx_hold;
        pwrMsg.phyReady && !pwrMsg.txAck && rxPwrState != LPS_PWR_INIT
            |=> $stable(rxPwrState);
    endproperty
    property p_phy_down;
        !pwrMsg.phyReady |=> txPwrState == LPS_PWR_INIT
            && rxPwrState == LPS_PWR_INIT;
    endproperty
    property p_phy_up;
        $rose(pwrMsg.phyReady) |-> ##[1:2] txPwrState == LPS_PWR_FULL
            && rxPwrState == LPS_PWR_FULL;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus request not answered next cycle");
    a_ack_drop: assert property (p_ack_drop)
        else $error("bus answer longer than one cycle");
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data not zero outside answer");
    a_own_accept: assert property (p_own_accept)
        else $error("tx state missed an accept");
    a_peer_accept: assert property (p_peer_accept)
        else $error("rx state missed an accept");
    a_tx_hold: assert property (p_tx_hold)
        else $error("tx state moved without accept");
    a_rx_hold: assert property (p_rx_hold)
        else $error("rx state moved without accept");
    a_phy_down: assert property (p_phy_down)
        else $error("states not back to training");
    a_phy_up: assert property (p_phy_up)
        else $error("states not full after training");
endmodule : lps_chk

// file: tb/lps_partner.sv
`timescale 1ns/1ps
module lps_partner
    import lps_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link-layer sources
    output lps_pkg::lpsDatapath_t llEvents,
    output lps_pkg::lpsPwrMsg_t pwrMsg
);
    integer seed = 52;
    logic [31:0] r;
    initial llEvents = '0;
    initial pwrMsg = '0;
    // ====================
    // fresh levels each cycle; credits kept small to hit the limits
    always @(posedge mclk) begin
        r = $random(seed);
        llEvents <= rst_n ? {r[3:0], 3'h0, r[6:4], 3'h0, r[9:7], 3'h0,
            r[12:10], r[19:13]} : '0;
    end
    task automatic phy(input logic up);
        @(posedge mclk);
        pwrMsg.phyReady <= up;
    endtask : phy
    // ====================
    // one request, one answer the next cycle, then all quiet
    task automatic ask(input logic own, input lpsPwr_t tgt, input logic ok);
        @(posedge mclk);
        pwrMsg.ourReq <= own;
        pwrMsg.peerReq <= !own;
        pwrMsg.ourReqTgt <= tgt;
        pwrMsg.peerReqTgt <= tgt;
        @(posedge mclk);
        pwrMsg.ourReq <= 1'b0;
        pwrMsg.peerReq <= 1'b0;
        pwrMsg.rxAck <= own & ok;
        pwrMsg.rxNack <= own & !ok;
        pwrMsg.txAck <= !own & ok;
        pwrMsg.txNack <= !own & !ok;
        @(posedge mclk);
        pwrMsg <= pwrMsg & 13'h1000;
    endtask : ask
endmodule : lps_partner

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import lps_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    lpsWbReq_t wbReq = '0;
    logic [31:0] wbDatO, rd, v;
    logic wbAck, hit, inc;
    lpsDatapath_t ev;
    lpsPwrMsg_t pm;
    lpsPwr_t txSt, rxSt;
    lpsPwr_t eTx = LPS_PWR_INIT;
    lpsPwr_t eRx = LPS_PWR_INIT;
    lpsPwr_t tgt [2];
    logic [1:0] pend = 2'h0;
    logic seen = 1'b0;
    logic [5:0] thrExp = LPS_THR_RST;
    logic [3:0] accOn = 4'h0;
    logic [3:0] prev = 4'h0;
    logic [31:0] ctl [4] = '{default: 32'h0};
    logic [31:0] acc [4] = '{default: 32'h0};
    logic [7:0] codes [13] = '{LPS_EV_TICK, LPS_EV_DIRECT, LPS_EV_BYP_BLK,
        LPS_EV_RXQ_BLK, LPS_EV_CRD_RET, LPS_EV_CRD_SHORT, LPS_EV_PHY_INIT,
        LPS_EV_SHUT_RES, LPS_EV_ACCEPT, LPS_EV_REFUSE, LPS_EV_RX_REDUCED,
        LPS_EV_SLOT2, 8'h30};
    integer seed = 52;
    int mismatches = 0;
    int checked = 0;
    lps_event_select lps_event_select_i (.mclk(mclk), .rst_n(rst_n),
        .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .llEvents(ev),
        .pwrMsg(pm), .txPwrState(txSt), .rxPwrState(rxSt));
    lps_partner lps_partner_i (.mclk(mclk), .rst_n(rst_n), .llEvents(ev),
        .pwrMsg(pm));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ====================
    // expected condition of one counter this cycle
    function automatic logic cond(input logic [31:0] c);
        logic [7:0] q;
        logic [5:0] r, d, a, t;
        logic s0, s1;
        r = ev.reqCredits;
        d = ev.dataCredits;
        a = ev.ackCredits;
        t = thrExp;
        s0 = pend[0] && tgt[0] == LPS_PWR_SHUT;
        s1 = pend[1] && tgt[1] == LPS_PWR_SHUT;
        case (c[7:0])
            LPS_EV_TICK: return 1'b1;
            LPS_EV_CRD_RET: return ev.crdRetBlocked;
            LPS_EV_SHUT_RES: return eTx == LPS_PWR_SHUT
                || eRx == LPS_PWR_SHUT;
            LPS_EV_RX_REDUCED: return eRx == LPS_PWR_REDUCED;
            LPS_EV_PHY_INIT: return eRx == LPS_PWR_INIT;
            LPS_EV_DIRECT: q = {6'h0, ev.drsToLink, ev.drsToCore}
                & {8{ev.drsValid & ev.drsCandidate}};
            LPS_EV_CRD_SHORT: q = {a == 3, a == 2, a == 1, a == 0,
                d == 0, r == 2, r == 1, r == 0};
            LPS_EV_BYP_BLK: q = {3'h0, ev.gvBlock, ev.bgfStall, a <= 3,
                d == 0, r <= 2};
            LPS_EV_RXQ_BLK: q = {1'b0, ev.gvBlock, ev.bgfStall, a <= 3,
                d > 0 && d <= t, d == 0, r > 2 && r <= t, r <= 2};
            LPS_EV_SLOT2: q = {4'h0, ev.slot2Ack, ev.slot2Vn1,
                ev.slot2Vn0, ev.slot2Vna};
            LPS_EV_ACCEPT: q = {6'h0, pm.txAck & s1, pm.rxAck & s0};
            LPS_EV_REFUSE: q = {6'h0, pm.txNack & s1, pm.rxNack & s0};
            default: q = 8'h0;
        endcase
        return |(q & c[15:8]);
    endfunction : cond
    function automatic logic [31:0] st();
        return {16'h0, LPS_XFER_PER_CLK, 3'h0, seen, 1'b0, eRx, 1'b0, eTx};
    endfunction : st
    // ====================
    // reference counters and power states, updated every edge
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            hit = cond(ctl[i]);
            inc = accOn[i] && hit && !(ctl[i][LPS_EDGE_BIT] && prev[i]);
            if (inc)
                acc[i] = acc[i] + 32'h1;
            if (inc && ctl[i][7:0] == LPS_EV_SHUT_RES)
                seen = 1'b1;
            prev[i] = hit;
        end
        if (!pm.phyReady) begin
            eTx = LPS_PWR_INIT;
            eRx = LPS_PWR_INIT;
            pend = 2'h0;
        end else begin
            eTx = (eTx == LPS_PWR_INIT) ? LPS_PWR_FULL : eTx;
            eRx = (eRx == LPS_PWR_INIT) ? LPS_PWR_FULL : eRx;
            if (pm.rxAck && pend[0])
                eTx = tgt[0];
            if (pm.txAck && pend[1])
                eRx = tgt[1];
            pend = pend & ~{pm.txAck | pm.txNack, pm.rxAck | pm.rxNack};
            pend = pend | {pm.peerReq, pm.ourReq};
            tgt[0] = pm.ourReq ? pm.ourReqTgt : tgt[0];
            tgt[1] = pm.peerReq ? pm.peerReqTgt : tgt[1];
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // classic single cycle, request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        @(posedge mclk);
        // no limit here: only the watchdog ends a wait
        while (wbAck !== 1'b1)
            @(posedge mclk);
        q = wbDatO;
        if (w && a < LPS_CNT0_OFF) begin
            ctl[a[3:2]] <= d;
            accOn[a[3:2]] <= d[LPS_EN_BIT];
        end
        if (w && a == LPS_STAT_OFF && d[8])
            seen <= 1'b0;
        wbReq <= '0;
        @(posedge mclk);
    endtask : wb
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // ====================
    // reset map, then random counter setups with power traffic
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        lps_partner_i.phy(1'b1);
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 11; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0, rd);
            chk("reset map", rd, i == 8 ? 32'(LPS_THR_RST)
                : i == 9 ? st() : 32'h0);
        end
        wb(1'b1, LPS_THR_OFF, 32'h0000_0005, rd);
        thrExp = 6'h05;
        wb(1'b0, LPS_THR_OFF, 32'h0, rd);
        chk("threshold", rd, 32'h0000_0005);
        for (int t = 0; t < 40; t++) begin
            if (t % 8 == 7)
                lps_partner_i.phy(1'b0);
            for (int i = 0; i < 4; i++) begin
                v = (32'($random(seed)) & 32'h0004ff00) | 32'h00400000
                    | 32'(codes[$unsigned($random(seed)) % 13]);
                wb(1'b1, 8'(4 * i), v & 32'hffbfffff, rd);
                acc[i] = 32'h0;
                wb(1'b1, 8'(16 + 4 * i), 32'h0, rd);
                wb(1'b1, 8'(4 * i), v, rd);
            end
            repeat (5 + $unsigned($random(seed)) % 20) @(posedge mclk);
            for (int k = 0; k < 2 && t % 8 != 7; k++)
                lps_partner_i.ask(k[0], lpsPwr_t'(3'(1 +
                    $unsigned($random(seed)) % 4)), 1'($random(seed)));
            for (int i = 0; i < 4; i++)
                wb(1'b1, 8'(4 * i), ctl[i] & 32'hffbfffff, rd);
            for (int i = 0; i < 4; i++) begin
                wb(1'b0, 8'(16 + 4 * i), 32'h0, rd);
                chk("count", rd, acc[i]);
            end
            if (t % 8 == 7)
                lps_partner_i.phy(1'b1);
            repeat (3) @(posedge mclk);
            wb(1'b0, LPS_STAT_OFF, 32'h0, rd);
            chk("status", rd, st());
            chk("tx state", 32'(txSt), 32'(eTx));
            chk("rx state", 32'(rxSt), 32'(eRx));
            wb(1'b1, LPS_STAT_OFF, 32'h100, rd);
        end
        complete_run();
    end
    // hang guard, well past the expected run length
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
endmodule : tb
bind lps_event_select lps_chk lps_chk_i (.mclk(mclk), .rst_n(rst_n),
    .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .llEvents(llEvents),
    .pwrMsg(pwrMsg), .txPwrState(txPwrState), .rxPwrState(rxPwrState));
